// file: psp_pkg.sv
// shared constants and types for the pipelined synchronous memory port
package psp_pkg;

	// organisation: 256K words of four 9-bit lanes (8 data bits plus one parity bit)
	localparam int ADDR_W = 18;
	localparam int DEPTH = 262144;
	localparam int LANES = 4;
	localparam int BYTE_W = 8;
	localparam int LANE_W = 9;
	localparam int DATA_W = 32;
	localparam int WORD_W = 36;

	// burst counter covers the two low address bits
	localparam int BURST_W = 2;
	localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

	// reset values
	localparam logic [WORD_W-1:0] WORD_RST = 36'h0_0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0_0000;
	localparam logic [LANES-1:0] LANES_OFF_N = 4'hf;

	// burst state remembered between a load and its advances
	typedef enum logic [1:0]
	{
		PSP_IDLE,
		PSP_READ_BURST,
		PSP_WRITE_BURST
	} psp_burst_t;

	// one accepted operation travelling down the pipeline
	typedef struct packed
	{
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] lanes_n;
	} psp_cmd_t;

	localparam psp_cmd_t CMD_IDLE = '{valid: 1'b0, write: 1'b0, addr: ADDR_RST,
		lanes_n: LANES_OFF_N};

endpackage : psp_pkg

// file: psp_store.sv
// storage array: one memory per byte lane, synchronous write, combinational read
`timescale 1ns/1ns
module psp_store
(
	input wire logic sys_clk,
	input wire logic wr_en,
	input wire logic [psp_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [psp_pkg::LANES-1:0] wr_lanes_n,
	input wire logic [psp_pkg::WORD_W-1:0] wr_word,
	input wire logic [psp_pkg::ADDR_W-1:0] rd_addr,
	output logic [psp_pkg::WORD_W-1:0] rd_word
);

	// no reset on the array: contents survive reset, sleep and a stopped clock
	genvar g;
	generate
		for (g = 0; g < psp_pkg::LANES; g++)
		begin : g_lane
			logic [psp_pkg::LANE_W-1:0] lane_mem [psp_pkg::DEPTH];

			always_ff @(posedge sys_clk)
			begin
				if (wr_en && !wr_lanes_n[g])
					lane_mem[wr_addr] <= wr_word[g*psp_pkg::LANE_W +: psp_pkg::LANE_W];
			end

			assign rd_word[g*psp_pkg::LANE_W +: psp_pkg::LANE_W] = lane_mem[rd_addr];
		end
	endgenerate

endmodule : psp_store

// file: psp_port.sv
// pipelined synchronous burst memory port, device side
//
// Behaviour
// - all synchronous inputs captured on rising edge
// - read data leaves through edge-clocked output registers
// - qualifier high freezes pipeline state and data outputs, not sleep_active
// - three chip selects accept; async enable gates drivers
// - drivers float during every write data cycle
// - reads and writes mix back to back freely
// - 256K by 36 pipelined burst storage
// - burst low bits linear or interleaved by input
// - sleep input idles port; contents always preserved
// - internal output control, no enable toggling needed
`timescale 1ns/1ns
module psp_port
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [psp_pkg::ADDR_W-1:0] addr,
	input wire logic chip_select_1_n,
	input wire logic chip_select_2,
	input wire logic chip_select_3_n,
	input wire logic write_enable_n,
	input wire logic burst_advance_or_load,
	input wire logic [psp_pkg::LANES-1:0] byte_lane_write_n,
	input wire logic clock_qualifier_n,
	input wire logic output_drive_n,
	input wire logic order_interleaved,
	input wire logic sleep_request,
	input wire logic [psp_pkg::DATA_W-1:0] data_in,
	input wire logic [psp_pkg::LANES-1:0] parity_lane_data_in,
	output logic [psp_pkg::DATA_W-1:0] data_out,
	output logic [psp_pkg::LANES-1:0] parity_lane_data_out,
	output logic data_oe,
	output logic sleep_active
);

	// next low address bits of a burst in the selected order
	function automatic logic [psp_pkg::BURST_W-1:0] burst_low
	(
		input logic interleaved,
		input logic [psp_pkg::BURST_W-1:0] start,
		input logic [psp_pkg::BURST_W-1:0] count
	);
		logic [psp_pkg::BURST_W-1:0] low;
		if (interleaved)
			low = start ^ count;
		else
			low = start + count;
		return low;
	endfunction : burst_low

	// pack pins into a stored word, lane i is {parity i, byte i}
	function automatic logic [psp_pkg::WORD_W-1:0] pack_word
	(
		input logic [psp_pkg::DATA_W-1:0] data,
		input logic [psp_pkg::LANES-1:0] parity
	);
		logic [psp_pkg::WORD_W-1:0] word;
		word = psp_pkg::WORD_RST;
		for (int i = 0; i < psp_pkg::LANES; i++)
			word[i*psp_pkg::LANE_W +: psp_pkg::LANE_W] =
				{parity[i], data[i*psp_pkg::BYTE_W +: psp_pkg::BYTE_W]};
		return word;
	endfunction : pack_word

	// stall: the qualifier is a synchronous input on the same clock as the controller
	logic stall;
	logic selected;
	logic sleep_meta_r;
	logic sleep_r;
	logic sleep_meta_nxt;
	logic sleep_nxt;

	psp_pkg::psp_burst_t burst_r;
	psp_pkg::psp_burst_t burst_nxt;
	logic [psp_pkg::ADDR_W-1:0] base_r;
	logic [psp_pkg::ADDR_W-1:0] base_nxt;
	logic [psp_pkg::BURST_W-1:0] count_r;
	logic [psp_pkg::BURST_W-1:0] count_nxt;
	logic order_r;
	logic order_nxt;

	psp_pkg::psp_cmd_t cap_r;
	psp_pkg::psp_cmd_t cap_nxt;
	psp_pkg::psp_cmd_t mid_r;
	psp_pkg::psp_cmd_t mid_nxt;

	logic [psp_pkg::WORD_W-1:0] dout_r;
	logic [psp_pkg::WORD_W-1:0] dout_nxt;
	logic drive_r;
	logic drive_nxt;

	logic mem_wr_en;
	logic [psp_pkg::WORD_W-1:0] mem_wr_word;
	logic [psp_pkg::WORD_W-1:0] mem_rd_word;

	assign stall = clock_qualifier_n;
	assign selected = !chip_select_1_n && chip_select_2 && !chip_select_3_n;

	// sleep request is asynchronous to the port clock, so two flops first
	// limitation: a request shorter than one clock may be missed
	always_comb
	begin
		sleep_meta_nxt = sleep_request;
		sleep_nxt = sleep_meta_r;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			sleep_meta_r <= 1'b0;
			sleep_r <= 1'b0;
		end
		else
		begin
			sleep_meta_r <= sleep_meta_nxt;
			sleep_r <= sleep_nxt;
		end
	end

	// capture stage: decode load, advance and deselect into one command
	always_comb
	begin
		burst_nxt = burst_r;
		base_nxt = base_r;
		count_nxt = count_r;
		order_nxt = order_r;
		cap_nxt = cap_r;
		if (!stall)
		begin
			cap_nxt = psp_pkg::CMD_IDLE;
			if (sleep_r)
			begin
				burst_nxt = psp_pkg::PSP_IDLE;
			end
			else if (!burst_advance_or_load)
			begin
				// load: a new operation only when all three selects are active
				if (selected)
				begin
					burst_nxt = write_enable_n ? psp_pkg::PSP_READ_BURST
						: psp_pkg::PSP_WRITE_BURST;
					base_nxt = addr;
					count_nxt = psp_pkg::BURST_ZERO;
					order_nxt = order_interleaved;
					cap_nxt.valid = 1'b1;
					cap_nxt.write = !write_enable_n;
					cap_nxt.addr = addr;
					cap_nxt.lanes_n = byte_lane_write_n;
				end
				else
				begin
					burst_nxt = psp_pkg::PSP_IDLE;
				end
			end
			else
			begin
				// advance: low bits generated here, upper bits held from the load
				unique case (burst_r)
					psp_pkg::PSP_IDLE:
					begin
						// an advance after a deselect or sleep issues nothing
						cap_nxt = psp_pkg::CMD_IDLE;
					end
					psp_pkg::PSP_READ_BURST,
					psp_pkg::PSP_WRITE_BURST:
					begin
						// the count wraps modulo four, so long bursts revisit the same words
						count_nxt = count_r + psp_pkg::BURST_STEP;
						cap_nxt.valid = 1'b1;
						cap_nxt.write = (burst_r == psp_pkg::PSP_WRITE_BURST);
						cap_nxt.addr = {base_r[psp_pkg::ADDR_W-1:psp_pkg::BURST_W],
							burst_low(order_r, base_r[psp_pkg::BURST_W-1:0],
							count_nxt)};
						cap_nxt.lanes_n = byte_lane_write_n;
					end
					default:
					begin
						// unused code: drop the burst rather than issue a stray access
						burst_nxt = psp_pkg::PSP_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			burst_r <= psp_pkg::PSP_IDLE;
			base_r <= psp_pkg::ADDR_RST;
			count_r <= psp_pkg::BURST_ZERO;
			order_r <= 1'b0;
			cap_r <= psp_pkg::CMD_IDLE;
		end
		else
		begin
			burst_r <= burst_nxt;
			base_r <= base_nxt;
			count_r <= count_nxt;
			order_r <= order_nxt;
			cap_r <= cap_nxt;
		end
	end

	// middle stage keeps read and write latencies equal
	always_comb
	begin
		mid_nxt = mid_r;
		if (!stall)
			mid_nxt = cap_r;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			mid_r <= psp_pkg::CMD_IDLE;
		else
			mid_r <= mid_nxt;
	end

	// data stage at edge N+2: writes take the data pins straight into the
	// array, reads load the output register. a read issued after a write
	// reaches this stage later, so it always sees the stored word and no
	// bypass is needed for back-to-back mixes.
	always_comb
	begin
		// a stalled edge writes nothing, so a held write lands exactly once
		mem_wr_en = !stall && mid_r.valid && mid_r.write;
		mem_wr_word = pack_word(data_in, parity_lane_data_in);
	end

	psp_store u_store
	(
		.sys_clk(sys_clk),
		.wr_en(mem_wr_en),
		.wr_addr(mid_r.addr),
		.wr_lanes_n(mid_r.lanes_n),
		.wr_word(mem_wr_word),
		.rd_addr(mid_r.addr),
		.rd_word(mem_rd_word)
	);

	always_comb
	begin
		dout_nxt = dout_r;
		drive_nxt = drive_r;
		if (!stall)
		begin
			if (mid_r.valid && !mid_r.write && !sleep_r)
			begin
				// read data cycle: refresh the output register and drive the pins
				dout_nxt = mem_rd_word;
				drive_nxt = 1'b1;
			end
			else if (mid_r.valid && mid_r.write)
			begin
				// write data cycle: the controller owns the bus, so float
				drive_nxt = 1'b0;
			end
			else
			begin
				// idle, deselect or a read refused by sleep: release the bus
				drive_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			dout_r <= psp_pkg::WORD_RST;
			drive_r <= 1'b0;
		end
		else
		begin
			dout_r <= dout_nxt;
			drive_r <= drive_nxt;
		end
	end

	// unpack the output register onto the pins
	genvar g;
	generate
		for (g = 0; g < psp_pkg::LANES; g++)
		begin : g_out
			assign data_out[g*psp_pkg::BYTE_W +: psp_pkg::BYTE_W] =
				dout_r[g*psp_pkg::LANE_W +: psp_pkg::BYTE_W];
			assign parity_lane_data_out[g] =
				dout_r[g*psp_pkg::LANE_W + psp_pkg::BYTE_W];
		end
	endgenerate

	// the async enable only gates; the timing comes from the internal drive flag
	assign data_oe = drive_r && !output_drive_n;
	assign sleep_active = sleep_r;

endmodule : psp_port

// file: psp_port_checker.sv
// concurrent checks on the memory port pins
`timescale 1ns/1ns
module psp_port_checker
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic chip_select_1_n,
	input wire logic chip_select_2,
	input wire logic chip_select_3_n,
	input wire logic write_enable_n,
	input wire logic burst_advance_or_load,
	input wire logic clock_qualifier_n,
	input wire logic output_drive_n,
	input wire logic sleep_request,
	input wire logic [psp_pkg::DATA_W-1:0] data_out,
	input wire logic [psp_pkg::LANES-1:0] parity_lane_data_out,
	input wire logic data_oe,
	input wire logic sleep_active
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	wire sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
	wire ld = !clock_qualifier_n && !burst_advance_or_load && !sleep_active;
	a_read_oe: assert property (ld && sel && write_enable_n ##1 !clock_qualifier_n [*2]
		|=> data_oe || output_drive_n || sleep_active) else $error("read not driven");
	a_write_float: assert property (ld && sel && !write_enable_n ##1 !clock_qualifier_n [*2]
		|=> !data_oe) else $error("driving in write data cycle");
	a_desel_idle: assert property (ld && !sel ##1 !clock_qualifier_n [*2]
		|=> !data_oe) else $error("deselect drove data");
	a_stall_hold: assert property (clock_qualifier_n
		|=> $stable(data_out) && $stable(parity_lane_data_out)) else $error("stall moved data");
	a_oe_gate: assert property (output_drive_n |-> !data_oe) else $error("enable ignored");
	a_out_edge: assert property ($changed(data_out)
		|-> !$past(clock_qualifier_n) || !$past(rstn)) else $error("data changed in stall");
	a_sleep_drive: assert property ((sleep_active && !clock_qualifier_n) [*3]
		|-> !data_oe) else $error("driving while asleep");
	a_sleep_sync: assert property ($stable(sleep_request) [*5]
		|-> sleep_active == sleep_request) else $error("sleep state wrong");
	c_read: cover property (ld && sel && write_enable_n);
	c_write: cover property (ld && sel && !write_enable_n);
	c_stall: cover property (clock_qualifier_n && data_oe);
endmodule : psp_port_checker
bind psp_port psp_port_checker u_psp_chk (.*);

// file: psp_ctrl_model.sv
// memory controller model: drives host pins and keeps a reference copy
`timescale 1ns/1ns
module psp_ctrl_model
(
	input wire logic sys_clk,
	input wire logic sleep_active,
	input wire logic order_interleaved,
	input wire logic [31:0] data_out,
	input wire logic [3:0] parity_lane_data_out,
	output logic [17:0] addr,
	output logic chip_select_1_n,
	output logic chip_select_2,
	output logic chip_select_3_n,
	output logic write_enable_n,
	output logic burst_advance_or_load,
	output logic [3:0] byte_lane_write_n,
	output logic clock_qualifier_n,
	output logic [31:0] data_in,
	output logic [3:0] parity_lane_data_in
);
	typedef struct packed
	{
		logic r;
		logic w;
		logic [17:0] a;
		logic [3:0] l;
		logic [35:0] d;
	} psp_op_t;
	psp_op_t s1 = '0, s2 = '0, cur = '0;
	logic [35:0] mem [logic [17:0]];
	logic [17:0] base = '0;
	logic [1:0] k = '0;
	logic bw = 0, bsel = 0, ord = 0, qn_r = 1, ld_r = 1;
	initial {addr, chip_select_1_n, chip_select_2, chip_select_3_n, write_enable_n,
		burst_advance_or_load, byte_lane_write_n, clock_qualifier_n, data_in,
		parity_lane_data_in} = '0;
	task automatic cyc(input logic ld, we, qn, input logic [2:0] cs, input logic [17:0] a,
		input logic [3:0] ln, input logic [35:0] wd, output logic chk, output logic [35:0] got,
		output logic [35:0] exp);
		@(negedge sys_clk);
		// order pin as it stood at the load edge just passed
		if (!qn_r && !ld_r) ord = order_interleaved;
		chk = s2.r && !qn_r;
		got = {parity_lane_data_out, data_out};
		if (!qn_r)
		begin
			if (chk)
				exp = mem[s2.a];
			for (int i = 0; i < 4; i++)
				if (s2.w && !s2.l[i])
				begin
					mem[s2.a][8*i+:8] = s2.d[8*i+:8];
					mem[s2.a][32+i] = s2.d[32+i];
				end
			s2 = s1;
			s1 = cur;
		end
		// released bus shows the inverse so a stale sample cannot pass
		{parity_lane_data_in, data_in} = s2.w ? s2.d : ~{parity_lane_data_in, data_in};
		if (!qn)
		begin
			if (!ld)
			begin
				base = a;
				k = '0;
				bw = !we;
				bsel = cs == 3'h2;
			end
			else
				k++;
		end
		bsel = bsel && !sleep_active;
		cur.a = {base[17:2], ord ? base[1:0] ^ k : base[1:0] + k};
		cur.r = bsel && !bw;
		cur.w = bsel && bw;
		cur.l = ln;
		cur.d = wd;
		addr = a;
		{chip_select_1_n, chip_select_2, chip_select_3_n} = cs;
		write_enable_n = we;
		burst_advance_or_load = ld;
		byte_lane_write_n = ln;
		clock_qualifier_n = qn;
		qn_r = qn;
		ld_r = ld;
	endtask : cyc
endmodule : psp_ctrl_model

// file: psp_port_test.sv
// self-checking bench for the memory port
`timescale 1ns/1ns
module psp_port_test;
	logic sys_clk = 0, rstn = 0, order_interleaved = 0, sleep_request = 0, output_drive_n = 0;
	logic chip_select_1_n, chip_select_2, chip_select_3_n, write_enable_n, data_oe;
	logic burst_advance_or_load, clock_qualifier_n, sleep_active;
	logic [17:0] addr;
	logic [3:0] byte_lane_write_n, parity_lane_data_in, parity_lane_data_out;
	logic [31:0] data_in, data_out;
	int n_fail = 0, num_checks = 0;
	psp_port DUT (.*);
	psp_ctrl_model pm (.*);
	always #20 sys_clk = ~sys_clk;
	function automatic logic [17:0] adr(input int i);
		// upper half lands at the top row to reach the last address
		return i[3] ? 18'h3fff0 | 18'(i) : 18'(i);
	endfunction : adr
	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok)
		begin
			n_fail++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task automatic op(input logic ld, we, qn, input logic [2:0] cs, input logic [17:0] a,
		input logic [3:0] ln);
		logic c;
		logic [35:0] g, e;
		pm.cyc(ld, we, qn, cs, a, ln, {4'($urandom), $urandom}, c, g, e);
		if (c) chk(g === e, "read data");
	endtask : op
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	initial
	begin
		void'($urandom(78));
		repeat (5) @(negedge sys_clk);
		rstn = 1;
		for (int i = 0; i < 16; i++) op(1'b0, 1'b0, 1'b0, 3'h2, adr(i), 4'h0);
		for (int i = 0; i < 16; i++) op(1'b0, 1'b1, 1'b0, 3'h2, adr(i), 4'h0);
		repeat (3) op(1'b0, 1'b1, 1'b0, 3'h0, 18'h0, 4'hf);
		$display("test fill done");
		for (int i = 0; i < 400; i++)
		begin
			order_interleaved = 1'($urandom);
			output_drive_n = ($urandom % 8) == 0;
			op(($urandom % 3) == 0, 1'($urandom), ($urandom % 5) == 0,
				($urandom % 4) != 0 ? 3'h2 : 3'($urandom), adr($urandom % 16), 4'($urandom));
		end
		output_drive_n = 0;
		repeat (3) op(1'b0, 1'b1, 1'b0, 3'h0, 18'h0, 4'hf);
		$display("test random mix done");
		sleep_request = 1;
		repeat (6) op(1'b0, 1'b0, 1'b0, 3'h2, adr($urandom % 16), 4'h0);
		chk(sleep_active === 1'b1 && data_oe === 1'b0, "sleep state");
		sleep_request = 0;
		repeat (5) op(1'b0, 1'b1, 1'b0, 3'h0, 18'h0, 4'hf);
		for (int i = 0; i < 16; i++) op(1'b0, 1'b1, 1'b0, 3'h2, adr(i), 4'hf);
		repeat (3) op(1'b0, 1'b1, 1'b0, 3'h0, 18'h0, 4'hf);
		$display("test sleep done");
		final_report;
	end
endmodule : psp_port_test
